//--- design/pshr_defines.vh
`ifndef PSHR_DEFINES_VH
`define PSHR_DEFINES_VH

// register width and stage reset value
`define PSHR_WIDTH 4
`define PSHR_STATE_RST 4'h0

// pin synchroniser: three stages, two compared
`define PSHR_SYNC_STAGES 3

// bit positions inside the synchronised pin vector
`define PSHR_PIN_MODE 0
`define PSHR_PIN_LOAD_CLK 1
`define PSHR_PIN_RIGHT_CLK 2
`define PSHR_PIN_SERIAL 3
`define PSHR_PIN_PAR_LO 4
`define PSHR_PIN_COUNT 8

`endif

//--- design/pshr_buf.v
`timescale 1ns/100ps

module pshr_buf #(
    parameter WIDTH = 4
) (
    input wire clock,
    input wire sys_rst,
    input wire [WIDTH-1:0] in_data,
    input wire in_valid,
    output reg in_ready,
    output reg [WIDTH-1:0] out_data,
    output reg out_valid,
    input wire out_ready
);

    // entry one is the output register, entry two a skid slot
    reg [WIDTH-1:0] skid_reg;
    reg skid_valid_reg;
    reg skid_valid_next;
    wire take;
    wire pop;

    assign take = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    always @* begin
        skid_valid_next = skid_valid_reg;
        if (!out_valid || pop) begin
            skid_valid_next = skid_valid_reg & take;
        end else if (take) begin
            skid_valid_next = 1'b1;
        end
    end

    always @(posedge clock) begin
        if (sys_rst) begin
            out_data <= {WIDTH{1'b0}};
            out_valid <= 1'b0;
            skid_reg <= {WIDTH{1'b0}};
            skid_valid_reg <= 1'b0;
            in_ready <= 1'b0;
        end else begin
            skid_valid_reg <= skid_valid_next;
            // ready is registered, so it must assume the worst next cycle
            in_ready <= ~skid_valid_next;
            if (!out_valid || pop) begin
                if (skid_valid_reg) begin
                    out_data <= skid_reg;
                    out_valid <= 1'b1;
                    if (take) begin
                        skid_reg <= in_data;
                    end
                end else begin
                    out_valid <= take;
                    if (take) begin
                        out_data <= in_data;
                    end
                end
            end else if (take) begin
                skid_reg <= in_data;
            end
        end
    end

endmodule

//--- design/pshr_top.v
`timescale 1ns/100ps
`include "pshr_defines.vh"

// Contract
// - four-bit state, only load or shift
// - mode high, load clock fall loads inputs; a fall is dropped while an older word waits for the buffer
// - serial input ignored while mode high
// - mode low, right clock fall shifts right; a fall is dropped while an older word waits for the buffer
// - mode changes alone never alter contents
// - unselected clock activity is ignored
// - all stages update together from old values
module pshr_top #(
    parameter WIDTH = `PSHR_WIDTH
) (
    input wire clock,
    input wire sys_rst,
    input wire mode_sel,
    input wire load_clk,
    input wire right_clk,
    input wire serial_in,
    input wire [3:0] par_in,
    output reg [3:0] par_out,
    output reg [3:0] word_data,
    output reg word_valid,
    input wire word_ready,
    output reg stall
);

    localparam PW = `PSHR_PIN_COUNT;

    wire [PW-1:0] pins;
    reg [PW-1:0] sync1_reg;
    reg [PW-1:0] sync2_reg;
    reg [PW-1:0] sync3_reg;
    reg [PW-1:0] lvl_reg;
    reg [PW-1:0] lvl_prev_reg;
    wire [PW-1:0] lvl_next;

    reg [3:0] state_next;
    reg op_hit;
    reg [3:0] push_data_reg;
    reg push_pend_reg;
    wire buf_ready;
    wire [3:0] buf_data;
    wire buf_valid;
    wire block_ops;
    wire stage_ready;

    wire mode_prev;
    wire load_fall;
    wire right_fall;
    wire serial_lvl;
    wire [3:0] par_lvl;

    assign pins = {par_in, serial_in, right_clk, load_clk, mode_sel};

    // a level counts only once stages two and three agree
    assign lvl_next = (~(sync2_reg ^ sync3_reg) & sync3_reg) |
                      ((sync2_reg ^ sync3_reg) & lvl_reg);

    always @(posedge clock) begin
        if (sys_rst) begin
            sync1_reg <= {PW{1'b0}};
            sync2_reg <= {PW{1'b0}};
            sync3_reg <= {PW{1'b0}};
            lvl_reg <= {PW{1'b0}};
            lvl_prev_reg <= {PW{1'b0}};
        end else begin
            sync1_reg <= pins;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
            lvl_reg <= lvl_next;
            lvl_prev_reg <= lvl_reg;
        end
    end

    // mode as it stood before the edge, so a mode change coinciding
    // with a clock fall uses the old mode
    assign mode_prev = lvl_prev_reg[`PSHR_PIN_MODE];
    assign load_fall = lvl_prev_reg[`PSHR_PIN_LOAD_CLK] &
                       ~lvl_reg[`PSHR_PIN_LOAD_CLK];
    assign right_fall = lvl_prev_reg[`PSHR_PIN_RIGHT_CLK] &
                        ~lvl_reg[`PSHR_PIN_RIGHT_CLK];
    assign serial_lvl = lvl_reg[`PSHR_PIN_SERIAL];
    assign par_lvl = lvl_reg[`PSHR_PIN_PAR_LO +: 4];

    // an older word still waiting for the buffer blocks new edges
    assign block_ops = push_pend_reg & ~buf_ready;

    always @* begin
        state_next = par_out;
        op_hit = 1'b0;
        if (!block_ops) begin
            if (mode_prev && load_fall) begin
                // left shift is this load with outputs wired back
                state_next = par_lvl;
                op_hit = 1'b1;
            end else if (!mode_prev && right_fall) begin
                state_next = {par_out[2:0], serial_lvl};
                op_hit = 1'b1;
            end
            // other clock and any mode change leave state alone
        end
    end

    always @(posedge clock) begin
        if (sys_rst) begin
            par_out <= `PSHR_STATE_RST;
            push_data_reg <= `PSHR_STATE_RST;
            push_pend_reg <= 1'b0;
            stall <= 1'b0;
        end else begin
            if (op_hit) begin
                par_out <= state_next;
                push_data_reg <= state_next;
                push_pend_reg <= 1'b1;
            end else if (buf_ready) begin
                push_pend_reg <= 1'b0;
            end
            stall <= block_ops;
        end
    end

    // output stage refills when empty or when its word is being taken
    assign stage_ready = ~word_valid | word_ready;

    pshr_buf #(
        .WIDTH(WIDTH)
    ) u_buf (
        .clock(clock),
        .sys_rst(sys_rst),
        .in_data(push_data_reg),
        .in_valid(push_pend_reg),
        .in_ready(buf_ready),
        .out_data(buf_data),
        .out_valid(buf_valid),
        .out_ready(stage_ready)
    );

    always @(posedge clock) begin
        if (sys_rst) begin
            word_data <= `PSHR_STATE_RST;
            word_valid <= 1'b0;
        end else if (stage_ready) begin
            // a held word stays put, so a receiver stall never repeats it
            word_data <= buf_data;
            word_valid <= buf_valid;
        end
    end

endmodule

//--- bench/pshr_chk.sv
`timescale 1ns/100ps
module pshr_chk (
    input wire clock,
    input wire sys_rst,
    input wire mode_sel,
    input wire load_clk,
    input wire right_clk,
    input wire serial_in,
    input wire [3:0] par_in,
    input wire [3:0] par_out,
    input wire [3:0] word_data,
    input wire word_valid,
    input wire word_ready,
    input wire stall
);
    reg [3:0] since = 4'h0;
    default clocking @(posedge clock);
    endclocking
    default disable iff (sys_rst);
    // cycles since a fall of the clock that the mode selects
    always @(posedge clock)
        since <= $fell(mode_sel ? load_clk : right_clk) ? 4'h0 :
            since + {3'h0, ~&since};
    a_rst_zero: assert property ($fell(sys_rst) |-> par_out == 4'h0)
        else $error("reset");
    a_hold_idle: assert property ($changed(par_out) |-> since < 4'ha
        || $past(stall)) else $error("hold");
    a_load_take: assert property ($fell(load_clk) && mode_sel &&
        word_ready |-> ##[1:9] par_out == $past(par_in)) else $error("load");
    a_right_step: assert property ($fell(right_clk) && !mode_sel &&
        word_ready |-> ##[1:9] par_out == {$past(par_out[2:0]), serial_in})
        else $error("shift");
    a_buf_hold: assert property (word_valid && !word_ready &&
        !$past(word_ready) |=> word_valid) else $error("valid");
    a_stall_full: assert property (stall |-> ##[0:2] word_valid)
        else $error("stall");
    a_word_cause: assert property ($rose(word_valid) |-> since < 4'hf)
        else $error("word");
    c_load: cover property ($fell(load_clk) && mode_sel);
    c_right: cover property ($fell(right_clk) && !mode_sel);
    c_stall: cover property (stall);
endmodule
bind pshr_top pshr_chk i_chk (.*);

//--- bench/pshr_board.sv
`timescale 1ns/100ps
module pshr_board (
    input wire clock,
    input wire [3:0] par_out,
    output reg mode_sel = 1'b0,
    output reg load_clk = 1'b0,
    output reg right_clk = 1'b0,
    output reg serial_in = 1'b0,
    output wire [3:0] par_in
);
    reg lw = 1'b0;
    reg [3:0] dat = 4'h0;
    assign par_in = lw ? {dat[3], par_out[3:1]} : dat;
    task wt;
        begin
            repeat (4) @(posedge clock);
            #1;
        end
    endtask
    task op(input m, l, r, s, w, input [3:0] d);
        begin
            mode_sel = m;
            wt;
            {load_clk, right_clk, serial_in, lw, dat} = {l, r, s, w, d};
            wt;
            {load_clk, right_clk} = 2'b00;
            wt;
            wt;
        end
    endtask
endmodule

//--- bench/tb_pshr_top.sv
`timescale 1ns/100ps
module tb_pshr_top;
    reg clock = 1'b0, sys_rst = 1'b1, word_ready = 1'b1;
    reg [15:0] rnd = 16'h33ed;
    reg [3:0] m = 4'h0;
    reg [3:0] q[$];
    wire mode_sel, load_clk, right_clk, serial_in, word_valid, stall;
    wire [3:0] par_in, par_out, word_data;
    integer n_mismatch = 0, comparisons = 0, i;
    pshr_top i_pshr_top (.*);
    pshr_board i_pshr_board (.*);
    initial forever #4 clock = ~clock;
    function [15:0] nx(input [15:0] v);
        nx = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    task cmp(input [3:0] got, exp);
        begin
            comparisons = comparisons + 1;
            if (got !== exp) begin
                n_mismatch = n_mismatch + 1;
                $display("mismatch %0t %h %h", $time, got, exp);
            end
        end
    endtask
    task results;
        begin
            if (n_mismatch == 0 && comparisons > 0)
                $display("Simulation passed");
            else
                $display("Simulation failed");
            $finish;
        end
    endtask
    // b: serial, feedback, right clock, load clock, mode
    task step(input [4:0] b);
        begin
            rnd = nx(rnd);
            // every accepted fall gives one word, changed or not
            if (b[1:0] == 2'b11) begin
                m = b[3] ? {rnd[11], m[3:1]} : rnd[11:8];
                q.push_back(m);
            end else if (b[2] && !b[0]) begin
                m = {m[2:0], b[4]};
                q.push_back(m);
            end
            i_pshr_board.op(b[0], b[1], b[2], b[4], b[3], rnd[11:8]);
        end
    endtask
    always @(posedge clock)
        if (word_valid === 1'b1 && word_ready && !sys_rst)
            if (q.size())
                cmp(word_data, q.pop_front());
            else
                cmp({3'h0, word_valid}, 4'h0);
    initial begin
        repeat (20) @(posedge clock);
        #1 sys_rst = 1'b0;
        cmp(par_out, 4'h0);
        for (i = 0; i < 60; i = i + 1) begin
            step(rnd[4:0]);
            cmp(par_out, m);
        end
        word_ready = 1'b0;
        for (i = 0; i < 8 && stall !== 1'b1; i = i + 1)
            step({rnd[4], 4'h3});
        cmp({3'h0, stall}, 4'h1);
        word_ready = 1'b1;
        for (i = 0; i < 40 && q.size(); i = i + 1)
            @(posedge clock);
        #1 cmp(4'(q.size()), 4'h0);
        cmp(par_out, m);
        results;
    end
endmodule
